// >>> pkg/eepf_pkg.sv
// constants, opcodes, status layout and state codes of the serial eeprom command front end
// assumes a 20 MHz reference clock that oversamples the host serial clock
package eepf_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int WRITE_CYCLE_MS = 5;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_MS * (CLK_HZ / 1000);
	localparam int TIMER_W = 17;

	localparam logic [7:0] OPC_SET_LATCH = 8'h06;
	localparam logic [7:0] OPC_CLEAR_LATCH = 8'h04;
	localparam logic [7:0] OPC_STATUS_FETCH = 8'h05;
	localparam logic [7:0] OPC_STATUS_STORE = 8'h01;
	localparam logic [7:0] OPC_ARRAY_FETCH = 8'h03;
	localparam logic [7:0] OPC_ARRAY_PROGRAM = 8'h02;

	localparam int SR_BUSY = 0;
	localparam int SR_LATCH = 1;
	localparam int SR_GUARD_LO = 2;
	localparam int SR_GUARD_HI = 3;
	localparam int SR_PPE = 7;
	localparam logic [7:0] SR_STORE_MASK = 8'h8c;
	localparam logic [7:0] SR_RESET = 8'h00;
	localparam logic [7:0] SR_BUSY_IMAGE = 8'hff;

	localparam int ADDR_W = 15;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [14:0] GUARD_QUARTER = 15'h6000;
	localparam logic [14:0] GUARD_HALF = 15'h4000;
	localparam logic [14:0] GUARD_FULL = 15'h0000;

	localparam int SYNC_W = 5;
	localparam int WORD_W = ADDR_W + 8;

	typedef enum logic [8:0] {
		ST_OPCODE = 9'h001,
		ST_ADDR = 9'h002,
		ST_PROG = 9'h004,
		ST_FETCH = 9'h008,
		ST_SR_OUT = 9'h010,
		ST_SR_IN = 9'h020,
		ST_LATCH_ON = 9'h040,
		ST_LATCH_OFF = 9'h080,
		ST_SKIP = 9'h100
	} eepf_state_t;
endpackage

// >>> pkg/eepf_stream_if.sv
// carrier for program words between the command logic and its two-entry buffer
// assumes both ends run on the reference clock
`timescale 1ns/100ps
interface eepf_stream_if;
	logic valid;
	logic ready;
	logic [eepf_pkg::WORD_W-1:0] word;
	modport src (output valid, output word, input ready);
	modport snk (input valid, input word, output ready);
endinterface

// >>> rtl/eepf_buf.sv
// two-entry buffer for program words; the head entry drives the outputs directly
// assumes the drain side is on the reference clock
`timescale 1ns/100ps
module eepf_buf (
	input wire logic clk,
	input wire logic rst,
	eepf_stream_if.snk in_s,
	output logic out_valid,
	output logic [eepf_pkg::WORD_W-1:0] out_word,
	input wire logic out_ready
);
	logic [eepf_pkg::WORD_W-1:0] tail_q;
	logic tail_v_q;
	logic pop;
	logic push;

	assign in_s.ready = !tail_v_q;
	assign pop = out_valid && out_ready;
	assign push = in_s.valid && !tail_v_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid <= 1'b0;
			tail_v_q <= 1'b0;
			out_word <= '0;
			tail_q <= '0;
		end else begin
			if (pop) begin
				out_valid <= tail_v_q || push;
				out_word <= tail_v_q ? tail_q : in_s.word;
				tail_v_q <= tail_v_q && push;
				tail_q <= in_s.word;
			end else if (push) begin
				if (out_valid) begin
					tail_v_q <= 1'b1;
					tail_q <= in_s.word;
				end else begin
					out_valid <= 1'b1;
					out_word <= in_s.word;
				end
			end
		end
	end
endmodule // eepf_buf

// >>> rtl/eepf_sync.sv
// two-flop synchroniser for the host pins
// assumes the pins are asynchronous to the reference clock
`timescale 1ns/100ps
module eepf_sync #(
	parameter int W = eepf_pkg::SYNC_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	// pins idle high, so reset to ones avoids false edges after reset
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= '1;
			sync_out <= '1;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // eepf_sync

// >>> rtl/eepf_top.sv
// command front end of a byte-organised serial eeprom, oversampling the host spi pins
// assumes an outside array that serves FETCH_DATA combinationally and drains PROG words
// Operation
// - capture input bits on serial clock rise
// - drive output bits on serial clock fall
// - chip select high: output off, standby
// - chip select low window frames each command
// - protect pin high never blocks programming
// - pin low plus enable bit: refuse status store
// - hold pause keeps transaction state
// - first byte enters eight-bit instruction register
// - undefined opcodes are silently ignored
// - set latch opcode is 06
// - clear latch opcode is 04
// - status fetch opcode is 05
// - status store opcode is 01
// - array fetch 03, array program 02
// - write cycle ends within 5 ms
// - latch set, cleared, auto-cleared after cycle
// - busy: only status fetch is served
// - sixteen address bits, top one ignored
// - status layout busy, latch, guards, enable
`timescale 1ns/100ps
module eepf_top #(
	parameter int WRITE_CYCLES = eepf_pkg::WRITE_CYCLE_CYC
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic CS_N,
	input wire logic SCK,
	input wire logic SI,
	input wire logic HOLD_N,
	input wire logic WP_N,
	output logic SO,
	output logic SO_OE,
	output logic [7:0] STATUS,
	output logic PROG_VALID,
	output logic [eepf_pkg::ADDR_W-1:0] PROG_ADDR,
	output logic [7:0] PROG_DATA,
	input wire logic PROG_READY,
	output logic PROG_START,
	output logic [eepf_pkg::ADDR_W-1:0] FETCH_ADDR,
	input wire logic [7:0] FETCH_DATA
);
	logic [eepf_pkg::SYNC_W-1:0] pins_s;
	logic cs_n_s, sck_s, si_s, hold_n_s, wp_n_s;
	logic sck_prev_q, cs_prev_q;
	logic rise, fall, cs_rise, cs_fall, active;
	eepf_pkg::eepf_state_t state_q;
	logic [2:0] bit_q;
	logic addr_byte_q;
	logic [7:0] shift_q;
	logic [7:0] byte_in;
	logic byte_done;
	logic [7:0] out_q;
	logic load_q;
	logic [eepf_pkg::ADDR_W-1:0] addr_q;
	logic prog_seen_q, sr_seen_q;
	logic [7:0] sr_new_q;
	logic busy_q;
	logic [eepf_pkg::TIMER_W-1:0] timer_q;
	logic pend_q;
	logic [eepf_pkg::WORD_W-1:0] pend_word_q;
	logic prog_go, sr_go, cycle_end, hw_guard;
	logic op_fetch_q, prog_take;
	logic [eepf_pkg::WORD_W-1:0] head_word;
	eepf_stream_if st_if ();

	function automatic logic guarded(input logic [eepf_pkg::ADDR_W-1:0] a, input logic [7:0] sr);
		logic [1:0] g;
		g = {sr[eepf_pkg::SR_GUARD_HI], sr[eepf_pkg::SR_GUARD_LO]};
		unique case (g)
			2'h0: guarded = 1'b0;
			2'h1: guarded = a >= eepf_pkg::GUARD_QUARTER;
			2'h2: guarded = a >= eepf_pkg::GUARD_HALF;
			2'h3: guarded = a >= eepf_pkg::GUARD_FULL;
		endcase
	endfunction

	eepf_sync #(.W(eepf_pkg::SYNC_W)) u_sync (
		.clk(REF_CLK),
		.rst(RST),
		.async_in({CS_N, SCK, SI, HOLD_N, WP_N}),
		.sync_out(pins_s)
	);
	assign {cs_n_s, sck_s, si_s, hold_n_s, wp_n_s} = pins_s;

	// a pause freezes edge detection, so no bit is counted while hold is low
	assign active = !cs_n_s && hold_n_s;
	assign rise = active && sck_s && !sck_prev_q;
	assign fall = active && !sck_s && sck_prev_q;
	assign cs_rise = cs_n_s && !cs_prev_q;
	assign cs_fall = !cs_n_s && cs_prev_q;
	assign byte_in = {shift_q[6:0], si_s};
	assign byte_done = rise && (bit_q == eepf_pkg::LAST_BIT);
	// the pin only counts together with the enable bit; pin high never blocks
	assign hw_guard = !wp_n_s && STATUS[eepf_pkg::SR_PPE];
	assign prog_go = cs_rise && state_q == eepf_pkg::ST_PROG && prog_seen_q && !busy_q
		&& STATUS[eepf_pkg::SR_LATCH];
	assign sr_go = cs_rise && state_q == eepf_pkg::ST_SR_IN && sr_seen_q && !busy_q
		&& STATUS[eepf_pkg::SR_LATCH] && !hw_guard;
	assign cycle_end = busy_q && timer_q == '0;
	// a byte is taken when the pending slot is free or empties at this very edge
	assign prog_take = byte_done && state_q == eepf_pkg::ST_PROG && !busy_q
		&& STATUS[eepf_pkg::SR_LATCH] && !guarded(addr_q, STATUS)
		&& (!pend_q || st_if.ready);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sck_prev_q <= 1'b0;
			cs_prev_q <= 1'b1;
		end else begin
			cs_prev_q <= cs_n_s;
			if (hold_n_s) begin
				sck_prev_q <= sck_s;
			end
		end
	end

	// bit and byte framing inside one chip select window
	always_ff @(posedge REF_CLK) begin
		if (RST || cs_n_s || cs_fall) begin
			bit_q <= '0;
			shift_q <= '0;
		end else if (rise) begin
			bit_q <= bit_q + 3'h1;
			shift_q <= byte_in;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (RST || cs_n_s) begin
			state_q <= eepf_pkg::ST_OPCODE;
			addr_byte_q <= 1'b0;
		end else if (byte_done) begin
			unique case (state_q)
				eepf_pkg::ST_OPCODE: begin
					if (byte_in == eepf_pkg::OPC_STATUS_FETCH) begin
						state_q <= eepf_pkg::ST_SR_OUT;
					end else if (busy_q) begin
						state_q <= eepf_pkg::ST_SKIP;
					end else if (byte_in == eepf_pkg::OPC_SET_LATCH) begin
						state_q <= eepf_pkg::ST_LATCH_ON;
					end else if (byte_in == eepf_pkg::OPC_CLEAR_LATCH) begin
						state_q <= eepf_pkg::ST_LATCH_OFF;
					end else if (byte_in == eepf_pkg::OPC_STATUS_STORE) begin
						state_q <= eepf_pkg::ST_SR_IN;
					end else if (byte_in == eepf_pkg::OPC_ARRAY_FETCH ||
						byte_in == eepf_pkg::OPC_ARRAY_PROGRAM) begin
						state_q <= eepf_pkg::ST_ADDR;
					end else begin
						state_q <= eepf_pkg::ST_SKIP;
					end
				end
				eepf_pkg::ST_ADDR: begin
					addr_byte_q <= 1'b1;
					if (addr_byte_q) begin
						state_q <= op_fetch_q ? eepf_pkg::ST_FETCH : eepf_pkg::ST_PROG;
					end
				end
				default: state_q <= state_q;
			endcase
		end
	end

	// remembers which of the two addressed opcodes opened the window
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			op_fetch_q <= 1'b0;
		end else if (byte_done && state_q == eepf_pkg::ST_OPCODE) begin
			op_fetch_q <= byte_in == eepf_pkg::OPC_ARRAY_FETCH;
		end
	end

	// address: sixteen bits arrive, the top one is dropped
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			addr_q <= '0;
		end else if (byte_done && state_q == eepf_pkg::ST_ADDR) begin
			if (addr_byte_q) begin
				addr_q <= {addr_q[6:0], byte_in};
			end else begin
				addr_q <= {8'h00, byte_in[6:0]};
			end
		end else if (prog_take) begin
			// advances per taken byte, so a dropped byte leaves no hole
			addr_q <= addr_q + 15'h0001;
		end
	end

	// outgoing byte: status image loaded on the last rise, array byte loaded one cycle after it
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			load_q <= 1'b0;
			FETCH_ADDR <= '0;
			out_q <= '0;
		end else begin
			load_q <= byte_done && ((state_q == eepf_pkg::ST_ADDR && addr_byte_q && op_fetch_q)
				|| state_q == eepf_pkg::ST_FETCH);
			if (byte_done && state_q == eepf_pkg::ST_ADDR && addr_byte_q) begin
				FETCH_ADDR <= {addr_q[6:0], byte_in};
			end
			if (byte_done && (state_q == eepf_pkg::ST_OPCODE || state_q == eepf_pkg::ST_SR_OUT)
				&& (state_q == eepf_pkg::ST_SR_OUT || byte_in == eepf_pkg::OPC_STATUS_FETCH)) begin
				out_q <= busy_q ? eepf_pkg::SR_BUSY_IMAGE : STATUS;
			end else if (load_q) begin
				out_q <= FETCH_DATA;
				// the array pointer wraps over the whole 15-bit space
				FETCH_ADDR <= FETCH_ADDR + 15'h0001;
			end else if (fall) begin
				out_q <= {out_q[6:0], 1'b0};
			end
		end
	end

	// serial output: changes only on a fall, released whenever chip select is up or hold is down
	always_ff @(posedge REF_CLK) begin
		if (RST || !active) begin
			SO_OE <= 1'b0;
			SO <= 1'b0;
		end else if (fall && (state_q == eepf_pkg::ST_SR_OUT || state_q == eepf_pkg::ST_FETCH)) begin
			SO_OE <= 1'b1;
			SO <= out_q[7];
		end
	end

	// program bytes: only whole bytes are kept, a stalled buffer holds the next one here
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pend_q <= 1'b0;
			pend_word_q <= '0;
			prog_seen_q <= 1'b0;
		end else begin
			if (cs_fall) begin
				prog_seen_q <= 1'b0;
			end else if (byte_done && state_q == eepf_pkg::ST_PROG && !busy_q
				&& STATUS[eepf_pkg::SR_LATCH] && !guarded(addr_q, STATUS)) begin
				prog_seen_q <= 1'b1;
			end
			// a new byte wins over the drain in the same cycle, so none is lost
			if (prog_take) begin
				pend_q <= 1'b1;
				pend_word_q <= {addr_q, byte_in};
			end else if (st_if.valid && st_if.ready) begin
				pend_q <= 1'b0;
			end
		end
	end
	assign st_if.valid = pend_q;
	assign st_if.word = pend_word_q;

	eepf_buf u_buf (
		.clk(REF_CLK),
		.rst(RST),
		.in_s(st_if),
		.out_valid(PROG_VALID),
		.out_word(head_word),
		.out_ready(PROG_READY)
	);
	assign {PROG_ADDR, PROG_DATA} = head_word;

	// status store data waits for the closing edge before it is applied
	always_ff @(posedge REF_CLK) begin
		if (RST || cs_fall) begin
			sr_seen_q <= 1'b0;
			sr_new_q <= '0;
		end else if (byte_done && state_q == eepf_pkg::ST_SR_IN && !sr_seen_q) begin
			sr_seen_q <= 1'b1;
			sr_new_q <= byte_in;
		end
	end

	// self-timed cycle: started by the closing edge of a complete program or status store
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			busy_q <= 1'b0;
			timer_q <= '0;
			PROG_START <= 1'b0;
		end else begin
			PROG_START <= prog_go;
			if (prog_go || sr_go) begin
				busy_q <= 1'b1;
				timer_q <= eepf_pkg::TIMER_W'(WRITE_CYCLES - 1);
			end else if (cycle_end) begin
				busy_q <= 1'b0;
			end else if (busy_q) begin
				timer_q <= timer_q - eepf_pkg::TIMER_W'(1);
			end
		end
	end

	// status image; a partial command never reaches here because all updates except the cycle-end latch and busy clears wait for cs_rise
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			STATUS <= eepf_pkg::SR_RESET;
		end else begin
			STATUS[eepf_pkg::SR_BUSY] <= busy_q || prog_go || sr_go;
			if (cycle_end) begin
				STATUS[eepf_pkg::SR_LATCH] <= 1'b0;
			end else if (cs_rise && !busy_q && state_q == eepf_pkg::ST_LATCH_ON) begin
				STATUS[eepf_pkg::SR_LATCH] <= 1'b1;
			end else if (cs_rise && !busy_q && state_q == eepf_pkg::ST_LATCH_OFF) begin
				STATUS[eepf_pkg::SR_LATCH] <= 1'b0;
			end
			if (sr_go) begin
				STATUS[eepf_pkg::SR_GUARD_LO] <= sr_new_q[eepf_pkg::SR_GUARD_LO];
				STATUS[eepf_pkg::SR_GUARD_HI] <= sr_new_q[eepf_pkg::SR_GUARD_HI];
				STATUS[eepf_pkg::SR_PPE] <= sr_new_q[eepf_pkg::SR_PPE];
			end
			STATUS[6:4] <= 3'h0;
		end
	end

	sequence s_opcode_in;
		byte_done && state_q == eepf_pkg::ST_OPCODE;
	endsequence
	sequence s_close_store;
		cs_rise && state_q == eepf_pkg::ST_SR_IN && sr_seen_q && hw_guard;
	endsequence

	chk_so_released: assert property (@(posedge REF_CLK) disable iff (RST)
		cs_n_s |=> !SO_OE) else $error("output driven with chip select high");
	chk_bit_capture: assert property (@(posedge REF_CLK) disable iff (RST)
		rise |=> shift_q[0] == $past(si_s)) else $error("input bit not captured on rise");
	chk_hold_freeze: assert property (@(posedge REF_CLK) disable iff (RST)
		(!hold_n_s && !cs_n_s) ##1 (!hold_n_s && !cs_n_s) |-> $stable(bit_q) && $stable(state_q))
		else $error("transaction state moved during hold");
	chk_unknown_skip: assert property (@(posedge REF_CLK) disable iff (RST)
		s_opcode_in and (byte_in > eepf_pkg::OPC_SET_LATCH) |=> state_q == eepf_pkg::ST_SKIP)
		else $error("undefined opcode not ignored");
	chk_busy_skip: assert property (@(posedge REF_CLK) disable iff (RST)
		s_opcode_in and busy_q and (byte_in != eepf_pkg::OPC_STATUS_FETCH)
		|=> state_q == eepf_pkg::ST_SKIP) else $error("command served while busy");
	chk_store_refused: assert property (@(posedge REF_CLK) disable iff (RST)
		s_close_store |=> $stable(STATUS[eepf_pkg::SR_PPE]) && !busy_q)
		else $error("status stored while protected");
	chk_latch_on: assert property (@(posedge REF_CLK) disable iff (RST)
		cs_rise && !busy_q && state_q == eepf_pkg::ST_LATCH_ON |=> STATUS[eepf_pkg::SR_LATCH])
		else $error("latch not set");
	chk_cycle_clear: assert property (@(posedge REF_CLK) disable iff (RST)
		cycle_end |=> !busy_q ##1 !STATUS[eepf_pkg::SR_LATCH] && !STATUS[eepf_pkg::SR_BUSY])
		else $error("cycle end did not clear busy and latch");
	chk_cycle_len: assert property (@(posedge REF_CLK) disable iff (RST)
		busy_q |-> timer_q < eepf_pkg::TIMER_W'(WRITE_CYCLES)) else $error("write cycle too long");
	chk_partial: assert property (@(posedge REF_CLK) disable iff (RST)
		cs_rise && state_q == eepf_pkg::ST_ADDR |=> $stable(STATUS[3:1]) && !busy_q)
		else $error("partial command changed state");
	chk_so_on_fall: assert property (@(posedge REF_CLK) disable iff (RST)
		SO_OE && !fall && !$rose(SO_OE) ##0 $past(active) |-> $stable(SO) or $past(fall))
		else $error("output changed away from a fall");
endmodule // eepf_top

// >>> testbench/eepf_host_model.sv
// host spi controller model: frames commands in modes 0 and 3, pauses with hold
// assumes the bench calls its tasks and hands it the output line gated by its enable
`timescale 1ns/100ps
module eepf_host_model (
	input wire logic clk,
	input wire logic so,
	output logic cs_n,
	output logic sck,
	output logic si,
	output logic hold_n
);
	logic mode3;
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b1;
		hold_n = 1'b1;
		mode3 = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	// clock idles at the mode's level and stands still outside frames
	task automatic open(input logic m3);
		mode3 = m3;
		sck <= m3;
		tick(2);
		cs_n <= 1'b0;
		tick(4);
	endtask
	task automatic close();
		sck <= mode3;
		tick(4);
		cs_n <= 1'b1;
		si <= ~si;
		tick(8);
	endtask
	// n bits msb first; a pause is taken with the clock low before bit hb
	task automatic shift(input logic [7:0] tx, input int n, input int hb,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			sck <= 1'b0;
			si <= tx[i];
			tick(4);
			if (i == hb) begin
				hold_n <= 1'b0;
				tick(12);
				hold_n <= 1'b1;
				tick(4);
			end
			sck <= 1'b1;
			rx[i] = so;
			tick(4);
		end
	endtask
endmodule // eepf_host_model

// >>> testbench/eepf_top_tb.sv
// self-checking bench for the serial eeprom command front end
// assumes the host model drives the pins and the bench plays the array side
`timescale 1ns/100ps
module eepf_top_tb;
	localparam int WC = 400;
	// power-up wait of 1 ms at the 50 ns reference period
	localparam int PUW = 20000;
	typedef struct {logic m3; logic [7:0] op; logic [7:0] exp;} eepf_row_t;
	eepf_row_t rows [6] = '{'{1'b0, 8'h06, 8'h02}, '{1'b1, 8'h04, 8'h00},
		'{1'b1, 8'h06, 8'h02}, '{1'b0, 8'ha5, 8'h02}, '{1'b0, 8'h04, 8'h00},
		'{1'b0, 8'hc6, 8'h00}};
	logic REF_CLK = 1'b0;
	logic RST = 1'b1;
	logic WP_N = 1'b1;
	logic PROG_READY = 1'b0;
	logic cs_n, sck, si, hold_n, so, so_oe, so_w, prog_valid, prog_start;
	logic [7:0] status, prog_data, fetch_data, rx, rx2;
	logic [14:0] prog_addr, fetch_addr;
	int mismatches = 0;
	int checked = 0;
	int starts = 0;
	int busy_cyc = 0;
	int n;
	always #25 REF_CLK = ~REF_CLK;
	// a released line shows the inverse, so a missing enable flips the bit seen
	assign so_w = so_oe ? so : ~so;
	assign fetch_data = fetch_addr[7:0] ^ 8'h5a;
	always @(posedge REF_CLK) if (prog_start === 1'b1) starts <= starts + 1;
	always @(posedge REF_CLK) if (status[0] === 1'b1) busy_cyc <= busy_cyc + 1;
	eepf_host_model host (.clk(REF_CLK), .so(so_w), .cs_n(cs_n), .sck(sck), .si(si),
		.hold_n(hold_n));
	eepf_top #(.WRITE_CYCLES(WC)) uut (.REF_CLK(REF_CLK), .RST(RST), .CS_N(cs_n),
		.SCK(sck), .SI(si), .HOLD_N(hold_n), .WP_N(WP_N), .SO(so), .SO_OE(so_oe),
		.STATUS(status), .PROG_VALID(prog_valid), .PROG_ADDR(prog_addr),
		.PROG_DATA(prog_data), .PROG_READY(PROG_READY), .PROG_START(prog_start),
		.FETCH_ADDR(fetch_addr), .FETCH_DATA(fetch_data));
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic send(input logic [7:0] b);
		logic [7:0] d;
		host.shift(b, 8, -1, d);
	endtask
	task automatic op1(input logic m3, input logic [7:0] op);
		host.open(m3);
		send(op);
		host.close();
	endtask
	task automatic store(input logic [7:0] v);
		host.open(1'b0);
		send(8'h01);
		send(v);
		host.close();
	endtask
	task automatic rd_sr(input logic m3, output logic [7:0] v);
		host.open(m3);
		send(8'h05);
		host.shift(8'h00, 8, -1, v);
		host.close();
	endtask
	task automatic wait_ready();
		int cnt;
		cnt = 0;
		while (status[0] !== 1'b0) begin
			@(negedge REF_CLK);
			cnt++;
			if (cnt > 1000) begin
				mismatches++;
				report_and_stop();
			end
		end
	endtask
	initial begin
		repeat (4) @(negedge REF_CLK);
		RST = 1'b0;
		repeat (4) @(negedge REF_CLK);
		check("status", status, 8'h00);
		check("so_oe", so_oe, 1'b0);
		repeat (PUW) @(negedge REF_CLK);
		foreach (rows[i]) begin
			op1(rows[i].m3, rows[i].op);
			check("status", status, rows[i].exp);
			rd_sr(rows[i].m3, rx);
			check("sr", rx, rows[i].exp);
			check("so_oe", so_oe, 1'b0);
		end
		// partial opcode cut by chip select
		host.open(1'b0);
		host.shift(8'h06, 7, -1, rx);
		host.close();
		check("partial", status, 8'h00);
		// status store starts a busy cycle that answers all ones
		op1(1'b0, 8'h06);
		busy_cyc = 0;
		store(8'h8c);
		rd_sr(1'b0, rx);
		check("busy sr", rx, 8'hff);
		op1(1'b0, 8'h06);
		wait_ready();
		check("busy len", 16'(busy_cyc >= WC && busy_cyc <= WC + 2), 16'h1);
		check("stored", status, 8'h8c);
		// protect pin low with enable bit set refuses the store
		WP_N = 1'b0;
		op1(1'b0, 8'h06);
		store(8'h00);
		check("wp refuse", status & 8'hfd, 8'h8c);
		WP_N = 1'b1;
		op1(1'b0, 8'h06);
		store(8'h00);
		wait_ready();
		check("wp high", status, 8'h00);
		// fetch ignores the top address bit and advances per byte
		host.open(1'b0);
		send(8'h03);
		send(8'h92);
		send(8'h34);
		host.shift(8'h00, 8, -1, rx);
		host.shift(8'h00, 8, -1, rx2);
		host.close();
		check("fetch0", rx, 8'h34 ^ 8'h5a);
		check("fetch1", rx2, 8'h35 ^ 8'h5a);
		// program without the latch is refused
		host.open(1'b0);
		send(8'h02);
		send(8'h00);
		send(8'h00);
		send(8'h55);
		host.close();
		check("no latch", 16'(starts), 16'h0);
		check("no word", prog_valid, 1'b0);
		// address cut short: nothing starts and the latch stays
		op1(1'b0, 8'h06);
		host.open(1'b0);
		send(8'h02);
		send(8'h01);
		host.close();
		check("cut start", 16'(starts), 16'h0);
		check("cut status", status, 8'h02);
		// four bytes into a stalled buffer, hold pause inside the first
		op1(1'b0, 8'h06);
		host.open(1'b0);
		send(8'h02);
		send(8'h01);
		send(8'h00);
		host.shift(8'h11, 8, 3, rx);
		send(8'h22);
		send(8'h33);
		send(8'h44);
		host.close();
		check("start", 16'(starts), 16'h1);
		check("stall", prog_valid, 1'b1);
		check("stall addr", prog_addr, 15'h0100);
		PROG_READY = 1'b1;
		n = 0;
		for (int k = 0; k < 20; k++) begin
			if (prog_valid === 1'b1) begin
				check("paddr", prog_addr, 16'(15'h0100 + n));
				check("pdata", prog_data, 16'(8'h11 * (n + 1)));
				n++;
			end
			@(negedge REF_CLK);
		end
		check("words", 16'(n), 16'h3);
		wait_ready();
		check("after prog", status, 8'h00);
		// reset in mid-run drops the latch and leaves the output released
		op1(1'b0, 8'h06);
		check("latch up", status, 8'h02);
		RST = 1'b1;
		repeat (4) @(negedge REF_CLK);
		RST = 1'b0;
		repeat (4) @(negedge REF_CLK);
		check("reset status", status, 8'h00);
		check("reset so_oe", so_oe, 1'b0);
		check("reset word", prog_valid, 1'b0);
		report_and_stop();
	end
endmodule // eepf_top_tb
